// ---- pkg/mpc_pkg.sv ----
package mpc_pkg;
   // Register byte addresses
   localparam logic [4:0] ADR_CDB_LO = 5'h00;
   localparam logic [4:0] ADR_CDB_MID = 5'h04;
   localparam logic [4:0] ADR_CDB_HI = 5'h08;
   localparam logic [4:0] ADR_CTRL = 5'h0C;
   localparam logic [4:0] ADR_STATUS = 5'h10;
   localparam logic [4:0] ADR_SENSE = 5'h14;
   localparam logic [4:0] ADR_SELECT = 5'h18;
   localparam logic [4:0] ADR_RESEL = 5'h1C;
   // Control and status bit positions
   localparam int CTRL_EXEC = 0;
   localparam int CTRL_FORMAT = 1;
   localparam int ST_CMD_ERR = 0;
   localparam int ST_SEL_ARMED = 1;
   localparam int ST_SPUN = 2;
   localparam int ST_MEDIUM = 3;
   localparam int ST_RESEL_FAIL = 4;
   localparam int ST_SEL_DONE = 5;
   localparam int ST_LEN_LSB = 8;
   localparam int ST_SENSE_KEY_LSB = 16;
   // Command codes
   localparam logic [7:0] OP_MODE_SELECT10 = 8'h55;
   localparam logic [7:0] OP_MODE_SENSE6 = 8'h1A;
   localparam logic [5:0] PAGE_READ_AHEAD = 6'h38;
   localparam logic [5:0] PAGE_ALL = 6'h3F;
   localparam logic [7:0] PAGE_LEN = 8'h0E;
   localparam logic [7:0] PAGE_TOTAL = 8'h10;
   localparam logic [3:0] SENSE_KEY_ABORTED = 4'hB;
   // Page byte 2 layout
   localparam int B2_CE = 4;
   localparam logic [3:0] SEG_WHOLE = 4'h0;
   localparam logic [3:0] SEG_FOUR = 4'h4;
   // Defaults and changeable masks
   localparam logic [7:0] DEF_B2 = 8'h10;
   localparam logic [7:0] DEF_THR = 8'h10;
   localparam logic [7:0] DEF_MAX = 8'h20;
   localparam logic [7:0] CHG_B2 = 8'h1F;
   localparam logic [7:0] CHG_THR = 8'hFF;
   localparam logic [7:0] CHG_MAX = 8'hFF;
   localparam logic [7:0] RESEL_DEF = 8'h00;
   typedef enum logic [1:0] {PC_CURRENT, PC_CHANGEABLE, PC_DEFAULT, PC_SAVED} mpc_pc_t;
endpackage : mpc_pkg

// ---- pkg/mpc_resel_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface mpc_resel_if;
   logic start;
   logic fail;
   logic ok;
   logic [7:0] limit;
   logic retry;
   logic abort;
   modport ctl (output start, fail, ok, limit, input retry, abort);
   modport eng (input start, fail, ok, limit, output retry, abort);
endinterface : mpc_resel_if
`default_nettype wire

// ---- src/mpc_decoder.sv ----
// Operation
// - Zero retry count: reselect forever
// - Exhausted retries: abort, aborted-command sense
// - Page code 38h, page length 0Eh
// - Savable bit only meaningful in sense data
// - Cache enable bit gates read-ahead
// - Byte2 enable+segments, byte3 threshold, byte4 max
// - Segments zero whole buffer, four split
// - Read-ahead only if length within threshold
// - Select opcode 55h, flags, length, control
// - Sense opcode 1Ah, field layout, zero bytes
// - Page control picks one of four sets
// - Reset loads current set from defaults
// - Medium ready: saved set becomes current
// - Select changes current only after spin-up
// - Format copies current into saved
// - Saved set written on format or on select with the SP bit set
// - Changeable set shows alterable bits
// - Truncate to allocation length, zero allowed
`timescale 1ns/10ps
`default_nettype none
module mpc_decoder import mpc_pkg::*; (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset,
   // Avalon-MM slave
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Drive state pins
   input wire logic i_spinup_done,
   input wire logic i_medium_ready,
   // Reselection events
   input wire logic i_resel_start,
   input wire logic i_resel_fail,
   input wire logic i_resel_ok,
   output logic o_resel_retry,
   output logic o_cmd_abort,
   // Read-ahead control and save strobe
   input wire logic i_xfer_valid,
   input wire logic [7:0] i_xfer_len,
   output logic o_ra_start,
   output logic o_ra_enable,
   output logic o_seg_four,
   output logic [7:0] o_max_prefetch,
   output logic o_save_write
);
   logic ack_r;
   logic [31:0] rdata_r;
   logic [7:0] cdb_r [0:9];
   logic [7:0] sel_buf_r [0:15];
   logic [1:0] spin_s_r, med_s_r;
   logic med_d_r;
   logic [7:0] cur_b2_r, cur_thr_r, cur_max_r;
   logic [7:0] sav_b2_r, sav_thr_r, sav_max_r;
   logic [7:0] snap_b2_r, snap_thr_r, snap_max_r;
   logic [7:0] sense_len_r, sense_idx_r, resel_lim_r;
   logic [15:0] plist_len_r, sel_idx_r;
   logic sel_armed_r, sel_sp_r, apply_r, err_r, sel_done_r, resel_fail_r, save_r;
   logic ra_start_r;
   logic [3:0] sense_key_r;

   mpc_resel_if rsi ();
   mpc_resel u_resel (.i_mclk(i_mclk), .i_reset(i_reset), .rs(rsi.eng));
   assign rsi.start = i_resel_start;
   assign rsi.fail = i_resel_fail;
   assign rsi.ok = i_resel_ok;
   assign rsi.limit = resel_lim_r;
   assign o_resel_retry = rsi.retry;
   assign o_cmd_abort = rsi.abort;

   // One wait state; side effects only on the completing edge
   wire logic req = i_avs_read || i_avs_write;
   wire logic wr_go = i_avs_write && ack_r;
   wire logic rd_go = i_avs_read && ack_r;
   assign o_avs_waitrequest = req && !ack_r;
   assign o_avs_readdata = rdata_r;

   wire logic spun = spin_s_r[1];
   wire logic med = med_s_r[1];
   wire logic med_rise = med && !med_d_r;
   wire logic exec = wr_go && i_avs_address == ADR_CTRL && i_avs_writedata[CTRL_EXEC];
   wire logic fmt_go = wr_go && i_avs_address == ADR_CTRL && i_avs_writedata[CTRL_FORMAT];
   wire logic op_sel = cdb_r[0] == OP_MODE_SELECT10;
   wire logic op_sense = cdb_r[0] == OP_MODE_SENSE6;
   wire mpc_pc_t pc = mpc_pc_t'(cdb_r[2][7:6]);
   wire logic [5:0] pcode = cdb_r[2][5:0];
   wire logic sense_ok = (pcode == PAGE_READ_AHEAD || pcode == PAGE_ALL)
      && cdb_r[1][4:0] == 5'h00 && cdb_r[3] == 8'h00;
   wire logic [15:0] plist_len = {cdb_r[7], cdb_r[8]};
   wire logic sel_wr = wr_go && i_avs_address == ADR_SELECT && sel_armed_r;

   // Merge only changeable bits of the sent page
   wire logic [7:0] m_b2 = (cur_b2_r & ~CHG_B2) | (sel_buf_r[2] & CHG_B2);
   wire logic [7:0] m_thr = (cur_thr_r & ~CHG_THR) | (sel_buf_r[3] & CHG_THR);
   wire logic [7:0] m_max = (cur_max_r & ~CHG_MAX) | (sel_buf_r[4] & CHG_MAX);
   // Savable bit in byte 0 of the sent page is ignored
   wire logic page_good = sel_buf_r[0][5:0] == PAGE_READ_AHEAD && sel_buf_r[1] == PAGE_LEN
      && (m_b2[3:0] == SEG_WHOLE || m_b2[3:0] == SEG_FOUR);
   wire logic apply_ok = apply_r && page_good && spun;

   function automatic logic [7:0] page_byte(input logic [7:0] idx);
      case (idx)
         8'h00: page_byte = {1'b1, 1'b0, PAGE_READ_AHEAD};
         8'h01: page_byte = PAGE_LEN;
         8'h02: page_byte = snap_b2_r;
         8'h03: page_byte = snap_thr_r;
         8'h04: page_byte = snap_max_r;
         default: page_byte = 8'h00;
      endcase
   endfunction

   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         spin_s_r <= 2'b00;
         med_s_r <= 2'b00;
         med_d_r <= 1'b0;
      end else begin
         spin_s_r <= {spin_s_r[0], i_spinup_done};
         med_s_r <= {med_s_r[0], i_medium_ready};
         med_d_r <= med;
      end
   end

   // Bus handshake and read data
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         ack_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
      end else begin
         ack_r <= req && !ack_r;
         if (i_avs_read && !ack_r) begin
            if (i_avs_address == ADR_CDB_LO) begin
               rdata_r <= {cdb_r[3], cdb_r[2], cdb_r[1], cdb_r[0]};
            end else if (i_avs_address == ADR_CDB_MID) begin
               rdata_r <= {cdb_r[7], cdb_r[6], cdb_r[5], cdb_r[4]};
            end else if (i_avs_address == ADR_CDB_HI) begin
               rdata_r <= {16'h0000, cdb_r[9], cdb_r[8]};
            end else if (i_avs_address == ADR_STATUS) begin
               rdata_r <= {12'h000, sense_key_r, sense_len_r, 2'b00, sel_done_r,
                  resel_fail_r, med, spun, sel_armed_r, err_r};
            end else if (i_avs_address == ADR_SENSE) begin
               rdata_r <= {24'h000000, (sense_idx_r < sense_len_r) ? page_byte(sense_idx_r)
                  : 8'h00};
            end else if (i_avs_address == ADR_RESEL) begin
               rdata_r <= {24'h000000, resel_lim_r};
            end else begin
               rdata_r <= 32'h0000_0000;
            end
         end
      end
   end

   // Command block and retry limit
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         for (int i = 0; i < 10; i++) begin
            cdb_r[i] <= 8'h00;
         end
         resel_lim_r <= RESEL_DEF;
      end else if (wr_go) begin
         for (int b = 0; b < 4; b++) begin
            if (i_avs_byteenable[b]) begin
               if (i_avs_address == ADR_CDB_LO) begin
                  cdb_r[b] <= i_avs_writedata[8*b +: 8];
               end else if (i_avs_address == ADR_CDB_MID) begin
                  cdb_r[b+4] <= i_avs_writedata[8*b +: 8];
               end else if (i_avs_address == ADR_CDB_HI && b < 2) begin
                  cdb_r[b+8] <= i_avs_writedata[8*b +: 8];
               end else if (i_avs_address == ADR_RESEL && b == 0) begin
                  resel_lim_r <= i_avs_writedata[7:0];
               end
            end
         end
      end
   end

   // Sense snapshot and read pointer
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         snap_b2_r <= 8'h00;
         snap_thr_r <= 8'h00;
         snap_max_r <= 8'h00;
         sense_len_r <= 8'h00;
         sense_idx_r <= 8'h00;
      end else if (exec && op_sense && sense_ok) begin
         case (pc)
            PC_CURRENT: begin
               snap_b2_r <= cur_b2_r;
               snap_thr_r <= cur_thr_r;
               snap_max_r <= cur_max_r;
            end
            PC_CHANGEABLE: begin
               snap_b2_r <= CHG_B2;
               snap_thr_r <= CHG_THR;
               snap_max_r <= CHG_MAX;
            end
            PC_DEFAULT: begin
               snap_b2_r <= DEF_B2;
               snap_thr_r <= DEF_THR;
               snap_max_r <= DEF_MAX;
            end
            default: begin
               snap_b2_r <= sav_b2_r;
               snap_thr_r <= sav_thr_r;
               snap_max_r <= sav_max_r;
            end
         endcase
         sense_len_r <= (cdb_r[4] < PAGE_TOTAL) ? cdb_r[4] : PAGE_TOTAL;
         sense_idx_r <= 8'h00;
      end else if (rd_go && i_avs_address == ADR_SENSE && sense_idx_r < sense_len_r) begin
         sense_idx_r <= sense_idx_r + 8'h01;
      end
   end

   // Select data collection
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         sel_armed_r <= 1'b0;
         sel_sp_r <= 1'b0;
         plist_len_r <= 16'h0000;
         sel_idx_r <= 16'h0000;
         apply_r <= 1'b0;
         for (int i = 0; i < 16; i++) begin
            sel_buf_r[i] <= 8'h00;
         end
      end else begin
         apply_r <= 1'b0;
         if (exec && op_sel) begin
            // Zero length moves no data and changes nothing
            sel_armed_r <= plist_len != 16'h0000;
            sel_sp_r <= cdb_r[1][0];
            plist_len_r <= plist_len;
            sel_idx_r <= 16'h0000;
         end else if (sel_wr) begin
            if (sel_idx_r < 16'h0010) begin
               sel_buf_r[sel_idx_r[3:0]] <= i_avs_writedata[7:0];
            end
            sel_idx_r <= sel_idx_r + 16'h0001;
            if (sel_idx_r + 16'h0001 == plist_len_r) begin
               sel_armed_r <= 1'b0;
               apply_r <= 1'b1;
            end
         end
      end
   end

   // Current and saved parameter sets
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         cur_b2_r <= DEF_B2;
         cur_thr_r <= DEF_THR;
         cur_max_r <= DEF_MAX;
      end else if (med_rise) begin
         cur_b2_r <= sav_b2_r;
         cur_thr_r <= sav_thr_r;
         cur_max_r <= sav_max_r;
      end else if (apply_ok) begin
         cur_b2_r <= m_b2;
         cur_thr_r <= m_thr;
         cur_max_r <= m_max;
      end
   end

   // Saved set stands for the copy kept on the medium
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         sav_b2_r <= DEF_B2;
         sav_thr_r <= DEF_THR;
         sav_max_r <= DEF_MAX;
         save_r <= 1'b0;
      end else begin
         save_r <= 1'b0;
         if (apply_ok && sel_sp_r) begin
            sav_b2_r <= m_b2;
            sav_thr_r <= m_thr;
            sav_max_r <= m_max;
            save_r <= 1'b1;
         end else if (fmt_go) begin
            sav_b2_r <= cur_b2_r;
            sav_thr_r <= cur_thr_r;
            sav_max_r <= cur_max_r;
            save_r <= 1'b1;
         end
      end
   end
   assign o_save_write = save_r;

   // Status flags; a new event beats a same-cycle clear
   wire logic st_clr = wr_go && i_avs_address == ADR_STATUS;
   wire logic err_set = (exec && !((op_sel) || (op_sense && sense_ok))) || (apply_r && !apply_ok);
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         err_r <= 1'b0;
         sel_done_r <= 1'b0;
         resel_fail_r <= 1'b0;
         sense_key_r <= 4'h0;
      end else begin
         if (err_set) begin
            err_r <= 1'b1;
         end else if (st_clr && i_avs_writedata[ST_CMD_ERR]) begin
            err_r <= 1'b0;
         end
         if (apply_ok) begin
            sel_done_r <= 1'b1;
         end else if (st_clr && i_avs_writedata[ST_SEL_DONE]) begin
            sel_done_r <= 1'b0;
         end
         if (rsi.abort) begin
            resel_fail_r <= 1'b1;
            sense_key_r <= SENSE_KEY_ABORTED;
         end else if (st_clr && i_avs_writedata[ST_RESEL_FAIL]) begin
            resel_fail_r <= 1'b0;
            sense_key_r <= 4'h0;
         end
      end
   end

   // Read-ahead decision
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         ra_start_r <= 1'b0;
      end else begin
         ra_start_r <= i_xfer_valid && cur_b2_r[B2_CE] && i_xfer_len <= cur_thr_r;
      end
   end
   assign o_ra_start = ra_start_r;
   assign o_ra_enable = cur_b2_r[B2_CE];
   assign o_seg_four = cur_b2_r[3:0] == SEG_FOUR;
   assign o_max_prefetch = cur_max_r;

   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_reset);

   AST_RA_OFF: assert property (!cur_b2_r[B2_CE] |=> !ra_start_r)
      else $error("read-ahead started while disabled");
   AST_RA_THR: assert property (i_xfer_valid && cur_b2_r[B2_CE] |=>
      ra_start_r == ($past(i_xfer_len) <= $past(cur_thr_r)))
      else $error("read-ahead threshold not honoured");
   AST_RESET_DEF: assert property ($past(i_reset) |-> cur_thr_r == DEF_THR && cur_b2_r == DEF_B2)
      else $error("current set not default after reset");
   AST_MEDIUM_LOAD: assert property (med_rise |=> cur_thr_r == $past(sav_thr_r)
      && cur_max_r == $past(sav_max_r))
      else $error("saved set not loaded at medium ready");
   AST_NO_SPIN: assert property (apply_r && !spun && !med_rise |=> $stable(cur_thr_r)
      && $stable(cur_b2_r) ##1 err_r)
      else $error("select changed set before spin-up");
   AST_FORMAT_SAVE: assert property (fmt_go && !apply_ok |=> sav_thr_r == $past(cur_thr_r)
      && o_save_write)
      else $error("format did not save current set");
   AST_TRUNC: assert property (exec && op_sense && sense_ok |=>
      sense_len_r == (($past(cdb_r[4]) < PAGE_TOTAL) ? $past(cdb_r[4]) : PAGE_TOTAL))
      else $error("sense length not truncated");
   AST_CHANGEABLE: assert property (exec && op_sense && sense_ok && pc == PC_CHANGEABLE |=>
      snap_b2_r == CHG_B2 && snap_thr_r == CHG_THR)
      else $error("changeable set wrong");
   AST_SEG: assert property (apply_ok |=> cur_b2_r[3:0] == SEG_WHOLE || cur_b2_r[3:0] == SEG_FOUR)
      else $error("unsupported segment count accepted");
   COV_SENSE: cover property (exec && op_sense && sense_ok ##[1:40] rd_go);
   COV_SELECT: cover property (apply_ok && sel_sp_r);
   COV_RA: cover property (ra_start_r);
endmodule : mpc_decoder
`default_nettype wire

// ---- src/mpc_resel.sv ----
`timescale 1ns/10ps
`default_nettype none
module mpc_resel (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset,
   // Control side
   mpc_resel_if.eng rs
);
   logic active_r;
   logic [7:0] cnt_r;
   logic retry_r;
   logic abort_r;
   wire logic last = (rs.limit != 8'h00) && (cnt_r + 8'h01 >= rs.limit);

   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         active_r <= 1'b0;
         cnt_r <= 8'h00;
         retry_r <= 1'b0;
         abort_r <= 1'b0;
      end else begin
         retry_r <= 1'b0;
         abort_r <= 1'b0;
         if (rs.start) begin
            active_r <= 1'b1;
            cnt_r <= 8'h00;
         end else if (rs.ok) begin
            active_r <= 1'b0;
         end else if (rs.fail && active_r) begin
            if (rs.limit == 8'h00) begin
               retry_r <= 1'b1;
            end else if (last) begin
               abort_r <= 1'b1;
               active_r <= 1'b0;
            end else begin
               retry_r <= 1'b1;
               cnt_r <= cnt_r + 8'h01;
            end
         end
      end
   end
   assign rs.retry = retry_r;
   assign rs.abort = abort_r;

   AST_RESEL_ENDLESS: assert property (@(posedge i_mclk) disable iff (i_reset)
      active_r && rs.fail && !rs.start && !rs.ok && rs.limit == 8'h00 |=> retry_r && !abort_r)
      else $error("zero retry count did not retry");
   AST_RESEL_ABORT: assert property (@(posedge i_mclk) disable iff (i_reset)
      active_r && rs.fail && !rs.start && !rs.ok && last |=> abort_r && !retry_r ##1 !abort_r)
      else $error("exhausted retries did not abort once");
   COV_RESEL_ABORT: cover property (@(posedge i_mclk) disable iff (i_reset) abort_r);
endmodule : mpc_resel
`default_nettype wire

// ---- test/mpc_initiator.sv ----
`timescale 1ns/10ps
`default_nettype none
module mpc_initiator (
   // Clock
   input wire logic i_mclk,
   // Requests from the target
   input wire logic i_retry,
   input wire logic i_abort,
   // Reselection outcome
   output logic o_start,
   output logic o_fail,
   output logic o_ok
);
   int gap = 1;
   bit fail_all = 1'b1;
   int retries = 0;
   int aborts = 0;

   initial begin
      o_start = 1'b0;
      o_fail = 1'b0;
      o_ok = 1'b0;
   end

   // Gap lets the bench make the initiator slow to answer
   task automatic attempt();
      repeat (gap) @(posedge i_mclk);
      if (fail_all) o_fail <= 1'b1;
      else o_ok <= 1'b1;
      @(posedge i_mclk);
      o_fail <= 1'b0;
      o_ok <= 1'b0;
   endtask : attempt

   task automatic open_seq();
      @(posedge i_mclk);
      o_start <= 1'b1;
      @(posedge i_mclk);
      o_start <= 1'b0;
      attempt();
   endtask : open_seq

   always @(posedge i_mclk) begin
      if (i_retry === 1'b1) begin
         retries++;
         fork
            attempt();
         join_none
      end
      if (i_abort === 1'b1) aborts++;
   end
endmodule : mpc_initiator
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench import mpc_pkg::*;;
   logic i_mclk, i_reset, rd, wr, spun, med, xv, wreq;
   logic retry, abort, ras, rae, seg4, savew, rs_start, rs_fail, rs_ok;
   logic [4:0] adr;
   logic [31:0] wd, q, rdata, st;
   logic [7:0] xl, mx;
   logic [7:0] pg [0:15];
   int fail_count = 0;
   int compares = 0;
   int saves = 0;
   int ra_cnt = 0;

   mpc_decoder u_mpc_decoder (.i_mclk(i_mclk), .i_reset(i_reset), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_spinup_done(spun),
      .i_medium_ready(med), .i_resel_start(rs_start), .i_resel_fail(rs_fail),
      .i_resel_ok(rs_ok), .o_resel_retry(retry), .o_cmd_abort(abort), .i_xfer_valid(xv),
      .i_xfer_len(xl), .o_ra_start(ras), .o_ra_enable(rae), .o_seg_four(seg4),
      .o_max_prefetch(mx), .o_save_write(savew));
   mpc_initiator u_mpc_initiator (.i_mclk(i_mclk), .i_retry(retry), .i_abort(abort),
      .o_start(rs_start), .o_fail(rs_fail), .o_ok(rs_ok));

   initial begin
      i_mclk = 1'b0;
      forever #20 i_mclk = ~i_mclk;
   end

   always @(posedge i_mclk) begin
      if (savew === 1'b1) saves++;
      if (ras === 1'b1) ra_cnt++;
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // Holds the request until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_mclk);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      // Waitrequest and read data are taken as they stand at the edge
      do begin
         @(posedge i_mclk);
         n++;
      end while (wreq !== 1'b0 && n < 20);
      chk("bus answer", 1, n < 20);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus

   task automatic sense(input logic [7:0] b2, input logic [7:0] alloc);
      bus(1, ADR_STATUS, 32'h31);
      bus(1, ADR_CDB_LO, {8'h00, b2, 8'h00, OP_MODE_SENSE6});
      bus(1, ADR_CDB_MID, {24'h0, alloc});
      bus(1, ADR_CTRL, 32'h1);
      bus(0, ADR_STATUS, 32'h0);
      st = q;
      for (int i = 0; i < 16; i++) begin
         bus(0, ADR_SENSE, 32'h0);
         pg[i] = q[7:0];
      end
   endtask : sense

   task automatic pchk(input string n, input logic [7:0] b2, t, m);
      logic [7:0] z;
      z = 8'h00;
      chk(n, {2'b10, PAGE_READ_AHEAD, PAGE_LEN, b2, t}, {pg[0], pg[1], pg[2], pg[3]});
      chk(n, m, pg[4]);
      for (int i = 5; i < 16; i++) z = z | pg[i];
      chk(n, 0, z);
      // Pin-driven status bits vary by scenario, so only length and error
      chk(n, {PAGE_TOTAL, 1'b0}, {st[15:8], st[ST_CMD_ERR]});
   endtask : pchk

   task automatic sel(input logic sp, input logic [7:0] b2, t, m);
      logic [7:0] p [0:15];
      p = '{default: 8'h00};
      p[0] = {2'b00, PAGE_READ_AHEAD};
      p[1] = PAGE_LEN;
      p[2] = b2;
      p[3] = t;
      p[4] = m;
      bus(1, ADR_STATUS, 32'h31);
      bus(1, ADR_CDB_LO, {16'h0, 7'h08, sp, OP_MODE_SELECT10});
      bus(1, ADR_CDB_MID, 32'h0);
      bus(1, ADR_CDB_HI, 32'h10);
      bus(1, ADR_CTRL, 32'h1);
      for (int i = 0; i < 16; i++) bus(1, ADR_SELECT, {24'h0, p[i]});
      repeat (3) @(posedge i_mclk);
      bus(0, ADR_STATUS, 32'h0);
   endtask : sel

   task automatic outs(input string n, input logic e, s, input logic [7:0] m);
      chk(n, {e, s, m}, {rae, seg4, mx});
   endtask : outs

   task automatic xfer(input logic [7:0] l, input int e);
      int c;
      c = ra_cnt;
      @(posedge i_mclk);
      xv <= 1'b1;
      xl <= l;
      @(posedge i_mclk);
      xv <= 1'b0;
      repeat (3) @(posedge i_mclk);
      chk("read-ahead start", e, ra_cnt - c);
   endtask : xfer

   task automatic t_reset();
      outs("reset outputs", DEF_B2[B2_CE], DEF_B2[3:0] == SEG_FOUR, DEF_MAX);
      bus(0, ADR_RESEL, 32'h0);
      chk("retry count reg", RESEL_DEF, q);
      $display("test reset done");
   endtask : t_reset

   task automatic t_sense();
      for (int pc = 0; pc < 4; pc++) begin
         sense({pc[1:0], PAGE_READ_AHEAD}, 8'h10);
         if (pc == 1) pchk("changeable set", CHG_B2, CHG_THR, CHG_MAX);
         else pchk("stored set", DEF_B2, DEF_THR, DEF_MAX);
      end
      sense({2'b00, PAGE_READ_AHEAD}, 8'h04);
      chk("truncated length", {8'h04, pg[4]}, {st[15:8], 8'h00});
      sense({2'b00, PAGE_READ_AHEAD}, 8'h00);
      chk("zero alloc", 0, {st[15:8], st[ST_CMD_ERR], pg[0]});
      sense({2'b00, 6'h32}, 8'h10);
      chk("foreign page", 1, st[ST_CMD_ERR]);
      $display("test sense done");
   endtask : t_sense

   task automatic t_select();
      sel(1, 8'h04, 8'h08, 8'h40);
      chk("select before spin-up", {1'b1, 8'd0}, {q[ST_CMD_ERR], saves[7:0]});
      outs("unchanged", 1, 0, DEF_MAX);
      spun <= 1'b1;
      sel(1, 8'h04, 8'h08, 8'h40);
      chk("select ok", {1'b0, 8'd1}, {q[ST_CMD_ERR], saves[7:0]});
      outs("after select", 0, 1, 8'h40);
      xfer(8'h01, 0);
      sense({2'b11, PAGE_READ_AHEAD}, 8'h10);
      pchk("saved after select", 8'h04, 8'h08, 8'h40);
      sel(0, 8'h02, 8'h08, 8'h40);
      chk("two segments", 1, q[ST_CMD_ERR]);
      sel(0, 8'h10, 8'h08, 8'h30);
      outs("one segment", 1, 0, 8'h30);
      chk("no save", 1, saves);
      xfer(8'h08, 1);
      xfer(8'h09, 0);
      $display("test select done");
   endtask : t_select

   task automatic t_format();
      bus(1, ADR_CTRL, 32'h2);
      repeat (3) @(posedge i_mclk);
      chk("format save", 2, saves);
      sense({2'b11, PAGE_READ_AHEAD}, 8'h10);
      pchk("saved after format", 8'h10, 8'h08, 8'h30);
      sel(0, 8'h14, 8'h08, 8'h50);
      outs("before medium", 1, 1, 8'h50);
      med <= 1'b1;
      repeat (5) @(posedge i_mclk);
      outs("medium loads saved", 1, 0, 8'h30);
      $display("test format done");
   endtask : t_format

   task automatic t_resel();
      bus(1, ADR_RESEL, 32'h3);
      u_mpc_initiator.retries = 0;
      u_mpc_initiator.open_seq();
      repeat (30) @(posedge i_mclk);
      chk("limited retries", {8'd2, 8'd1}, {u_mpc_initiator.retries[7:0],
         u_mpc_initiator.aborts[7:0]});
      bus(0, ADR_STATUS, 32'h0);
      chk("abort sense", {SENSE_KEY_ABORTED, 1'b1}, {q[19:16], q[ST_RESEL_FAIL]});
      bus(1, ADR_RESEL, 32'h0);
      u_mpc_initiator.gap = 2;
      u_mpc_initiator.open_seq();
      repeat (60) @(posedge i_mclk);
      chk("endless retries", {1'b1, 8'd1}, {u_mpc_initiator.retries > 12,
         u_mpc_initiator.aborts[7:0]});
      u_mpc_initiator.fail_all = 1'b0;
      repeat (10) @(posedge i_mclk);
      $display("test reselect done");
   endtask : t_resel

   task automatic results();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : results

   initial begin
      #(40 * 20000);
      fail_count++;
      results();
   end

   initial begin
      {i_reset, rd, wr, spun, med, xv, adr, wd, xl} = {1'b1, 50'h0};
      repeat (5) @(posedge i_mclk);
      i_reset <= 1'b0;
      t_reset();
      t_sense();
      t_select();
      t_format();
      t_resel();
      results();
   end
endmodule : testbench
`default_nettype wire
